// *** hw/adcm_params.svh ***
// constants of the multiplexed converter serial interface block
`ifndef ADCM_PARAMS_SVH
`define ADCM_PARAMS_SVH
`define ADCM_CLK_KHZ      125000
`define ADCM_OSC_HZ       153600
`define ADCM_CLK_HZ       125000000
`define ADCM_CONV60_MS    133
`define ADCM_CONV50_MS    160
`define ADCM_SCK_DIV      8
`define ADCM_FRAME_BITS   24
`define ADCM_RES_W        23
`define ADCM_OFS_CTRL     32'h0000_0000
`define ADCM_OFS_STATUS   32'h0000_0004
`define ADCM_OFS_IRQ_STAT 32'h0000_0008
`define ADCM_OFS_IRQ_MASK 32'h0000_000c
`define ADCM_OFS_RESULT   32'h0000_0010
`define ADCM_CTRL_RESTART 0
`define ADCM_IRQ_W        4
`define ADCM_MASK_RESET   4'h0
`endif

// *** hw/adcm_pkg.sv ***
// types shared by the converter serial interface block
package adcm_pkg;
  typedef enum logic [2:0]
  {
    ST_CONVERT = 3'b001,
    ST_SLEEP   = 3'b010,
    ST_DOUT    = 3'b100
  } adcm_state_e;

  // latched ahb address phase
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
  } adcm_aphase_s;

  // interrupt events, bit order of the status register
  typedef struct packed
  {
    logic mux_err;
    logic abort;
    logic frame_done;
    logic conv_done;
  } adcm_evt_s;
endpackage : adcm_pkg

// *** hw/adcm_sync.sv ***
// two-flop synchronisers for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module adcm_sync
  import adcm_pkg::*;
#(
  parameter int          W    = 1,
  parameter logic [31:0] INIT = 32'h0000_0000
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  initial
  begin
    if (W < 1 || W > 32)
      $error("adcm_sync: width out of range");
  end

  // first stage read only by the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i]     <= INIT[i];
          sync_out[i] <= INIT[i];
        end
        else
        begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : adcm_sync
`default_nettype wire

// *** hw/adcm_mux.sv ***
// channel selection shifter and latch
`timescale 1ns/100ps
`default_nettype none
module adcm_mux
  import adcm_pkg::*;
#(
  parameter int CH_W = 8
)
(
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // synchronised pin events
  input  wire logic            shift_rise,
  input  wire logic            latch_high,
  input  wire logic            latch_fall,
  input  wire logic            din,
  // selected channel enables
  output logic      [CH_W-1:0] channel_output
);
  logic [3:0] shreg;
  logic [2:0] nbits;

  initial
  begin
    if (CH_W != 8)
      $error("adcm_mux: three code bits need eight channels");
  end

  // decode of a four-bit word into channel enables
  function automatic logic [CH_W-1:0] decode(input logic [3:0] w);
    logic [CH_W-1:0] r;
    r = '0;
    if (w[3])
      r[w[2:0]] = 1'b1;
    return r;
  endfunction : decode

  // shift only while the latch select is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg <= 4'h0;
      nbits <= 3'h0;
    end
    else if (latch_fall)
    begin
      shreg <= 4'h0;
      nbits <= 3'h0;
    end
    else if (shift_rise && latch_high)
    begin
      shreg <= {shreg[2:0], din};
      if (nbits != 3'h4)
        nbits <= nbits + 3'h1;
    end
  end

  // latch on falling select; short or all-zero words keep the channel
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      channel_output <= '0;
    else if (latch_fall && nbits == 3'h4 && shreg != 4'h0)
      channel_output <= decode(shreg);
  end
endmodule : adcm_mux
`default_nettype wire

// *** hw/adcm_top.sv ***
// converter serial interface with ahb-lite register access
`timescale 1ns/100ps
`default_nettype none
`include "adcm_params.svh"
module adcm_top
  import adcm_pkg::*;
#(
  parameter int CONV60_CYC = `ADCM_CONV60_MS * `ADCM_CLK_KHZ,
  parameter int CONV50_CYC = `ADCM_CONV50_MS * `ADCM_CLK_KHZ,
  parameter int OSC_DIV    = `ADCM_CLK_HZ / `ADCM_OSC_HZ
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic      [31:0]           hrdata,
  output logic                       hresp,
  output logic                       irq,
  // converter pins
  input  wire logic                  converter_select_n,
  input  wire logic                  sck_in,
  output logic                       sck_out,
  output logic                       sck_oe,
  output logic                       sdo_out,
  output logic                       sdo_oe,
  input  wire logic                  rejection_clock_select,
  // multiplexer pins
  input  wire logic                  mux_clk,
  input  wire logic                  channel_select_latch_n,
  input  wire logic                  mux_din,
  output logic      [7:0]            channel_output,
  // modulator result
  input  wire logic [`ADCM_RES_W-1:0] conv_result
);
  ////////////////////////////////////////////////////////////////////////////
  logic        rst_q1;
  logic        rst_n;
  logic [4:0]  pin_s;
  logic        cs_n_s, sck_s, mclk_s, latch_s, din_s;
  logic        cs_n_d, sck_d, mclk_d, latch_d;
  logic        cs_fall, cs_rise, ext_rise, ext_fall;
  logic        sck_rise, sck_fall;
  adcm_state_e state;
  logic        int_mode;
  logic [1:0]  init_cnt;
  logic [31:0] conv_cnt;
  logic [15:0] osc_cnt;
  logic        osc_tick;
  logic [1:0]  sck_cnt;
  logic        gen_rise, gen_fall;
  logic [4:0]  fall_cnt;
  logic [`ADCM_FRAME_BITS-1:0] sreg;
  logic [`ADCM_RES_W-1:0] result;
  logic [7:0]  conv_channel;
  logic        start_conv;
  logic        restart;
  adcm_evt_s   evt;
  logic [`ADCM_IRQ_W-1:0] irq_stat, irq_mask;
  adcm_aphase_s ap;

  initial
  begin
    // the tick counter is sixteen bits wide
    if (OSC_DIV < 2 || OSC_DIV > 65536
        || CONV60_CYC < 1 || CONV50_CYC < 1)
      $error("adcm_top: timing parameters out of range");
  end

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins cross into clk; select and sck idle high, the rest low, matching
  // the edge detector reset so no false edge follows reset
  adcm_sync #(.W(5), .INIT(32'h0000_0018)) u_sync
  (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({sck_in, converter_select_n, channel_select_latch_n,
                mux_clk, mux_din}),
    .sync_out (pin_s)
  );
  assign {sck_s, cs_n_s, latch_s, mclk_s, din_s} = pin_s;

  // delayed copies for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {cs_n_d, sck_d, mclk_d, latch_d} <= 4'hc;
    else
      {cs_n_d, sck_d, mclk_d, latch_d} <= {cs_n_s, sck_s, mclk_s, latch_s};
  end

  assign cs_fall  = cs_n_d & ~cs_n_s;
  assign cs_rise  = ~cs_n_d & cs_n_s;
  assign ext_rise = ~sck_d & sck_s;
  assign ext_fall = sck_d & ~sck_s;
  // external edges count only in external mode, pin is input there
  assign sck_rise = int_mode ? gen_rise : ext_rise;
  assign sck_fall = int_mode ? gen_fall : ext_fall;

  ////////////////////////////////////////////////////////////////////////////
  // clock mode: sampled after reset settles and on every select fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_cnt <= 2'h0;
      int_mode <= 1'b1;
    end
    else
    begin
      if (init_cnt != 2'h3)
        init_cnt <= init_cnt + 2'h1;
      if (init_cnt == 2'h2 || cs_fall)
        int_mode <= sck_s;
    end
  end

  // internal oscillator tick, paces the internal serial clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_cnt  <= 16'h0000;
      osc_tick <= 1'b0;
    end
    else
    begin
      osc_tick <= (osc_cnt == 16'(OSC_DIV - 1));
      osc_cnt  <= (osc_cnt == 16'(OSC_DIV - 1)) ? 16'h0000 : osc_cnt + 16'h1;
    end
  end

  // internal serial clock, four ticks per half period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_cnt  <= 2'h0;
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      gen_rise <= 1'b0;
      gen_fall <= 1'b0;
    end
    else
    begin
      sck_oe   <= int_mode & ~cs_n_s;
      gen_rise <= 1'b0;
      gen_fall <= 1'b0;
      if (!int_mode || cs_n_s || state == ST_CONVERT)
      begin
        sck_cnt <= 2'h0;
        sck_out <= 1'b0;
      end
      else if (osc_tick)
      begin
        sck_cnt <= sck_cnt + 2'h1;
        if (sck_cnt == 2'h3)
        begin
          sck_out  <= ~sck_out;
          gen_rise <= ~sck_out;
          gen_fall <= sck_out;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign restart    = ap.valid & ap.write & (ap.addr == `ADCM_OFS_CTRL)
                    & hwdata[`ADCM_CTRL_RESTART];
  assign start_conv = (state == ST_DOUT && cs_rise)
                    || (state == ST_DOUT && sck_fall
                        && fall_cnt == 5'(`ADCM_FRAME_BITS - 1))
                    || (state != ST_CONVERT && restart);

  // conversion, sleep and data output sequence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_CONVERT;
      conv_cnt <= 32'h0000_0000;
      fall_cnt <= 5'h00;
    end
    else if (start_conv)
    begin
      state    <= ST_CONVERT;
      // rate taken per conversion, so rates never mix
      conv_cnt <= rejection_clock_select ? 32'(CONV50_CYC - 1)
                                         : 32'(CONV60_CYC - 1);
      fall_cnt <= 5'h00;
    end
    else
    begin
      unique case (state)
        ST_CONVERT:
        begin
          if (conv_cnt == 32'h0000_0000)
            state <= ST_SLEEP;
          else
            conv_cnt <= conv_cnt - 32'h1;
        end
        ST_SLEEP:
        begin
          if (sck_rise && !cs_n_s)
            state <= ST_DOUT;
        end
        ST_DOUT:
        begin
          if (sck_fall)
            fall_cnt <= fall_cnt + 5'h01;
        end
      endcase
    end
  end

  // result word loads at completion and shifts on falling edges
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sreg   <= '0;
      result <= '0;
    end
    else if (state == ST_CONVERT && conv_cnt == 32'h0000_0000 && !start_conv)
    begin
      sreg   <= {1'b0, conv_result};   // leading zero is the done flag
      result <= conv_result;
    end
    else if (state == ST_DOUT && sck_fall)
      sreg <= {sreg[`ADCM_FRAME_BITS-2:0], 1'b0};
  end

  // serial output driver
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdo_oe  <= 1'b0;
      sdo_out <= 1'b1;
    end
    else
    begin
      sdo_oe  <= ~cs_n_s;
      sdo_out <= (state == ST_CONVERT) | sreg[`ADCM_FRAME_BITS-1];
    end
  end

  // channel in use, caught as each conversion starts
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      conv_channel <= 8'h00;
    else if (start_conv)
      conv_channel <= channel_output;
  end

  ////////////////////////////////////////////////////////////////////////////
  adcm_mux #(.CH_W(8)) u_mux
  (
    .clk            (clk),
    .rst_n          (rst_n),
    .shift_rise     (~mclk_d & mclk_s),
    .latch_high     (latch_s),
    .latch_fall     (latch_d & ~latch_s),
    .din            (din_s),
    .channel_output (channel_output)
  );

  ////////////////////////////////////////////////////////////////////////////
  // events; shifting outside sleep flags a misuse
  assign evt.conv_done  = (state == ST_CONVERT) && conv_cnt == 32'h0
                          && !start_conv;
  assign evt.frame_done = (state == ST_DOUT) && sck_fall
                          && fall_cnt == 5'(`ADCM_FRAME_BITS - 1);
  assign evt.abort      = (state == ST_DOUT) && cs_rise;
  assign evt.mux_err    = ~mclk_d & mclk_s & latch_s
                          & (state != ST_SLEEP);

  // sticky status, set wins over a write-one clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat <= '0;
      irq_mask <= `ADCM_MASK_RESET;
      irq      <= 1'b0;
    end
    else
    begin
      if (ap.valid && ap.write && ap.addr == `ADCM_OFS_IRQ_STAT)
        irq_stat <= (irq_stat & ~hwdata[`ADCM_IRQ_W-1:0]) | evt;
      else
        irq_stat <= irq_stat | evt;
      if (ap.valid && ap.write && ap.addr == `ADCM_OFS_IRQ_MASK)
        irq_mask <= hwdata[`ADCM_IRQ_W-1:0];
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ahb-lite: zero wait states, read data fetched in the address phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap        <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ap.valid  <= hsel & hready & htrans[1];
      ap.write  <= hwrite;
      ap.addr   <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
      begin
        unique case (haddr[7:0])
          `ADCM_OFS_STATUS:
            hrdata <= {16'h0, conv_channel, 2'b0, sdo_out, int_mode,
                       1'b0, state};
          `ADCM_OFS_IRQ_STAT: hrdata <= {28'h0, irq_stat};
          `ADCM_OFS_IRQ_MASK: hrdata <= {28'h0, irq_mask};
          `ADCM_OFS_RESULT:   hrdata <= {9'h0, result};
          default:            hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sdo_hiz: assert property (cs_n_s |=> !sdo_oe)
    else $error("sdo driven while select high");
  a_sdo_pending: assert property
    (state == ST_CONVERT && !cs_n_s |=> sdo_out)
    else $error("pending flag not high during conversion");
  a_sleep_hold: assert property
    (state == ST_SLEEP && !sck_rise && !restart
     |=> state == ST_SLEEP)
    else $error("sleep left without clock rise");
  a_abort_start: assert property
    (state == ST_DOUT && cs_rise |=> state == ST_CONVERT)
    else $error("abort did not start conversion");
  a_frame_end: assert property
    (state == ST_DOUT && sck_fall && fall_cnt == 5'd23
     |=> state == ST_CONVERT ##1 sdo_out)
    else $error("conversion not started on edge 24");
  a_sck_input: assert property (!int_mode |=> !sck_oe)
    else $error("clock pin driven in external mode");
  a_mode_sample: assert property
    (cs_fall |=> int_mode == $past(sck_s))
    else $error("clock mode not sampled at select fall");
  a_shift_edge: assert property
    (state == ST_DOUT && !sck_fall && !start_conv |=> $stable(sreg))
    else $error("output word moved without falling edge");
  a_chan_latch: assert property
    (latch_d && !latch_s |-> ##[0:1] 1'b1 ##1 $stable(channel_output)
     [*2])
    else $error("channel output unsettled after latch");
  a_mux_hold: assert property
    (!latch_s && !(latch_d && !latch_s) |=> $stable(channel_output))
    else $error("channel changed while latch select low");

  c_dout: cover property (state == ST_SLEEP ##1 state == ST_DOUT);
  c_abort: cover property (evt.abort);
  c_frame: cover property (evt.frame_done);
  c_chan: cover property ($changed(channel_output));
endmodule : adcm_top
`default_nettype wire

// *** sim/adcm_host.sv ***
// host-side partner model for the converter and multiplexer pins
`timescale 1ns/100ps
`default_nettype none
module adcm_host
(
  // clock
  input  wire logic clk,
  // converter pins
  output logic      converter_select_n,
  output logic      sck_in,
  input  wire logic sck_out,
  input  wire logic sck_oe,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  // multiplexer pins
  output logic      mux_clk,
  output logic      channel_select_latch_n,
  output logic      mux_din
);
  logic sck_drv;
  logic sck_en;
  logic sdo_last;
  logic sdo_line;

  //////////////////////////////////////////////////////////////////////////
  // weak pull-up on the clock pin while nobody drives it
  assign sck_in   = sck_oe ? sck_out : (sck_en ? sck_drv : 1'b1);
  // a released data line must not show a stale bit
  assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;

  // last driven level of the data line
  always @(posedge clk)
    if (sdo_oe)
      sdo_last <= sdo_out;

  // idle pin levels from time zero
  initial
  begin
    converter_select_n     = 1'b1;
    sck_drv                = 1'b0;
    sck_en                 = 1'b1;
    sdo_last               = 1'b0;
    mux_clk                = 1'b0;
    channel_select_latch_n = 1'b0;
    mux_din                = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // enable bit first, then the code; caller keeps to sleep
  task automatic prog_mux(input logic [3:0] w);
    channel_select_latch_n <= 1'b1;
    tick(8);
    for (int i = 3; i >= 0; i--)
    begin
      mux_din <= w[i];
      tick(8);
      mux_clk <= 1'b1;
      tick(8);
      mux_clk <= 1'b0;
    end
    mux_din <= ~w[0];
    tick(8);
    channel_select_latch_n <= 1'b0;
    tick(8);
  endtask : prog_mux

  // shift clocks with the latch low, to be ignored
  task automatic stray_clk();
    mux_din <= 1'b1;
    repeat (4)
    begin
      mux_clk <= 1'b1;
      tick(8);
      mux_clk <= 1'b0;
      tick(8);
    end
  endtask : stray_clk

  // host-clocked read; fewer than 24 bits leaves an abort to the caller
  task automatic read_frame(input int nb, input int half,
                            output logic [23:0] d);
    d = 24'h0;
    sck_en  <= 1'b1;
    sck_drv <= 1'b0;
    tick(half);
    converter_select_n <= 1'b0;
    tick(half);
    for (int i = 0; i < nb; i++)
    begin
      d = {d[22:0], sdo_line};
      sck_drv <= 1'b1;
      tick(half);
      sck_drv <= 1'b0;
      tick(half);
    end
  endtask : read_frame

  task automatic deselect();
    converter_select_n <= 1'b1;
    tick(10);
  endtask : deselect

  // clock pin released ten cycles before select fall; period of the driven clock
  task automatic int_probe(output int per);
    int n;
    sck_en <= 1'b0;
    tick(10);
    converter_select_n <= 1'b0;
    n   = 0;
    per = 0;
    while (sck_out !== 1'b1 && n < 500)
    begin
      tick(1);
      n++;
    end
    while (sck_out !== 1'b0 && n < 500)
    begin
      tick(1);
      n++;
    end
    while (sck_out !== 1'b1 && n < 500)
    begin
      tick(1);
      n++;
      per++;
    end
    while (sck_out !== 1'b0 && n < 500)
    begin
      tick(1);
      n++;
      per++;
    end
  endtask : int_probe
endmodule : adcm_host
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the converter serial interface block
`timescale 1ns/100ps
`default_nettype none
`include "adcm_params.svh"
module testbench;
  logic                   clk;
  logic                   reset_n;
  logic                   hsel;
  logic                   hwrite;
  logic [1:0]             htrans;
  logic [31:0]            haddr;
  logic [31:0]            hwdata;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic                   irq;
  logic                   converter_select_n;
  logic                   sck_in;
  logic                   sck_out;
  logic                   sck_oe;
  logic                   sdo_out;
  logic                   sdo_oe;
  logic                   rejection_clock_select;
  logic                   mux_clk;
  logic                   channel_select_latch_n;
  logic                   mux_din;
  logic [7:0]             channel_output;
  logic [`ADCM_RES_W-1:0] conv_result;
  logic [31:0]            rd;
  logic [23:0]            frame;
  logic [11:0]            rows [10];
  int                     per;
  int                     err_count;
  int                     checked;

  //////////////////////////////////////////////////////////////////////////
  // short conversions keep the run small
  adcm_top #(.CONV60_CYC(200), .CONV50_CYC(300), .OSC_DIV(2)) dut
  (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .irq(irq), .converter_select_n(converter_select_n),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .rejection_clock_select(rejection_clock_select), .mux_clk(mux_clk),
    .channel_select_latch_n(channel_select_latch_n), .mux_din(mux_din),
    .channel_output(channel_output), .conv_result(conv_result)
  );

  adcm_host host
  (
    .clk(clk), .converter_select_n(converter_select_n), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .mux_clk(mux_clk), .mux_din(mux_din),
    .channel_select_latch_n(channel_select_latch_n)
  );

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp)
      err_count++;
  endtask : chk

  // ready is never assumed; only the watchdog ends a stuck wait
  task automatic wait_ready();
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : ahb

  task automatic wait_state(input logic [2:0] s);
    int n;
    n  = 0;
    rd = 32'h0;
    while (rd[2:0] !== s && n < 400)
    begin
      ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
      n++;
    end
    chk(rd[2:0], s);
  endtask : wait_state

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    rejection_clock_select = 1'b1;
    conv_result = 23'h2d5a3c;
    err_count = 0;
    checked = 0;
    // word to shift beside the channel enables it should give
    rows = '{12'h801, 12'h001, 12'h902, 12'ha04, 12'hb08,
             12'hc10, 12'hd20, 12'h500, 12'hf80, 12'he40};
    repeat (4) @(posedge clk);
    chk(hreadyout, 32'h0);
    chk(channel_output, 32'h0);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    ahb(1'b1, 32'h20, 32'hffff_ffff);
    ahb(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 32'h0);
    ahb(1'b0, `ADCM_OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h0);
    wait_state(3'b010);
    chk(sdo_oe, 32'h0);
    for (int i = 0; i < 10; i++)
    begin
      host.prog_mux(rows[i][11:8]);
      chk(channel_output, rows[i][7:0]);
    end
    host.stray_clk();
    chk(channel_output, 32'h40);
    wait_state(3'b010);
    // full frame, prompt host
    host.read_frame(24, 10, frame);
    chk(frame, {9'h0, conv_result});
    chk(sdo_out, 32'h1);
    conv_result <= 23'h52a5c3;
    host.deselect();
    chk(sdo_oe, 32'h0);
    ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'b001);
    chk(rd[15:8], 32'h40);
    ahb(1'b0, `ADCM_OFS_RESULT, 32'h0);
    chk(rd, 32'h2d5a3c);
    // interrupt: masked, unmasked, cleared
    ahb(1'b0, `ADCM_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 32'h0);
    ahb(1'b1, `ADCM_OFS_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    ahb(1'b1, `ADCM_OFS_IRQ_STAT, 32'h2);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
    ahb(1'b0, `ADCM_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h1);
    // slow rate still converting here, fast rate already done below
    repeat (200) @(posedge clk);
    ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'b001);
    wait_state(3'b010);
    rejection_clock_select <= 1'b0;
    // slow host aborts after five bits
    host.read_frame(5, 20, frame);
    chk(frame[4:0], {1'b0, conv_result[22:19]});
    host.deselect();
    ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'b001);
    ahb(1'b0, `ADCM_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'h5);
    repeat (230) @(posedge clk);
    ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'b010);
    // software restart from sleep, then a zero word shifted while converting
    ahb(1'b1, `ADCM_OFS_CTRL, 32'h1);
    ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
    chk(rd[2:0], 3'b001);
    host.prog_mux(4'h0);
    chk(channel_output, 32'h40);
    ahb(1'b0, `ADCM_OFS_IRQ_STAT, 32'h0);
    chk(rd, 32'hd);
    wait_state(3'b010);
    // internal clock mode
    host.int_probe(per);
    chk(32'(per), 32'd16);
    chk(sck_oe, 32'h1);
    host.deselect();
    chk(sck_oe, 32'h0);
    summarize();
  end

  // watchdog well beyond the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
